/* pkg/ffio_params.svh */
// constants for the fft frame streaming interface
`ifndef FFIO_PARAMS_SVH
`define FFIO_PARAMS_SVH

// default transform size in complex points
`define FFIO_DEF_POINTS 256
// default sample width in bits per real or imaginary part
`define FFIO_DEF_BITS 16
// narrowest and widest sample width the buffers can carry
`define FFIO_MIN_BITS 8
`define FFIO_MAX_BITS 16
// smallest and largest transform size
`define FFIO_MIN_POINTS 32
`define FFIO_MAX_POINTS 2048
// depth of the elastic fifo in front of the input buffer
`define FFIO_FIFO_DEPTH 8
// value of pointers and counts after reset or start
`define FFIO_PTR_RST 'h0
// accept flag value right after reset: a fresh frame may load
`define FFIO_ACCEPT_RST 1'b1

`endif

/* pkg/ffio_pkg.sv */
// types shared by the fft frame streaming interface
`include "ffio_params.svh"
package ffio_pkg;

   // one complex sample, each part held at the widest width
   typedef struct packed {
      logic [`FFIO_MAX_BITS-1:0] re;  // real part, two's complement
      logic [`FFIO_MAX_BITS-1:0] im;  // imaginary part
   } ffio_cplx_s;

   // phase of the input side
   typedef enum logic [1:0] {
      ST_FILL,   // collecting samples of a frame
      ST_WAIT,   // frame complete, output buffer still busy
      ST_COPY    // frame moving into the output buffer
   } ffio_in_state_e;

endpackage

/* logic/ffio_fifo.sv */
// elastic fifo with valid and ready on both sides
`timescale 1ns/1ps
`include "ffio_params.svh"
module ffio_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = `FFIO_FIFO_DEPTH
) (
   input  wire logic                     sys_clk,
   input  wire logic                     rst_n,
   input  wire logic                     clear,
   input  wire logic                     wr_valid,
   output logic                          wr_ready,
   input  wire logic [WIDTH-1:0]         wr_data,
   output logic                          rd_valid,
   input  wire logic                     rd_ready,
   output logic [WIDTH-1:0]              rd_data,
   output logic [$clog2(DEPTH+1)-1:0]    level
);
   localparam int AW = $clog2(DEPTH);

   // depth must be a power of two for the wrapping pointers
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("ffio_fifo: DEPTH must be a power of two >= 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];   // storage words
   logic [AW-1:0]    wp;            // write pointer
   logic [AW-1:0]    rp;            // read pointer
   wire              push = wr_valid & wr_ready;
   wire              pop  = rd_valid & rd_ready;

   // honest flags straight from the level
   assign wr_ready = (level != DEPTH[$clog2(DEPTH+1)-1:0]);
   assign rd_valid = (level != '0);
   assign rd_data  = mem[rp];

   // pointers and level; clear empties the fifo
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wp    <= '0;
         rp    <= '0;
         level <= '0;
      end else if (clear) begin
         wp    <= '0;
         rp    <= '0;
         level <= '0;
      end else begin
         wp    <= wp + AW'(push);
         rp    <= rp + AW'(pop);
         level <= level + ($clog2(DEPTH+1))'(push)
                        - ($clog2(DEPTH+1))'(pop);
      end
   end

   // word storage
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wp] <= wr_data;
      end
   end
endmodule

/* logic/ffio_frame_ram.sv */
// frame buffer with one write port and one registered read port
`timescale 1ns/1ps
`include "ffio_params.svh"
module ffio_frame_ram #(
   parameter int WIDTH = 32,
   parameter int DEPTH = `FFIO_DEF_POINTS
) (
   input  wire logic                     sys_clk,
   input  wire logic                     wr_en,
   input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input  wire logic [WIDTH-1:0]         wr_data,
   input  wire logic                     rd_en,
   input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output logic [WIDTH-1:0]              rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];   // one frame of samples

   // write, and read that holds its word until the next read
   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule

/* logic/ffio_top.sv */
// frame load and result read streaming interface of the fft core
`timescale 1ns/1ps
`include "ffio_params.svh"
module ffio_top
   import ffio_pkg::*;
#(
   parameter int POINTS = `FFIO_DEF_POINTS,
   parameter int BITS   = `FFIO_DEF_BITS
) (
   input  wire logic            sys_clk,
   input  wire logic            rst_n,
   input  wire logic            start,
   input  wire logic [BITS-1:0] in_real_bus,
   input  wire logic [BITS-1:0] in_imag_bus,
   input  wire logic            in_sample_valid,
   output logic                 input_accept_flag,
   input  wire logic            output_advance,
   output logic                 result_ready,
   output logic                 out_sample_valid,
   output logic [BITS-1:0]      out_real_bus,
   output logic [BITS-1:0]      out_imag_bus
);
   import ffio_pkg::*;

   localparam int AW = $clog2(POINTS);      // buffer address width
   localparam int CW = AW + 1;              // count width up to N
   localparam int FD = `FFIO_FIFO_DEPTH;    // fifo depth
   localparam int LW = $clog2(FD + 1);      // fifo level width
   localparam logic [CW-1:0] N_CNT = CW'(POINTS);
   localparam logic [AW-1:0] LAST  = AW'(POINTS - 1);
   localparam logic [LW-1:0] ROOM  = LW'(FD - 1);

   // refuse sizes the buffers cannot serve
   if (POINTS < `FFIO_MIN_POINTS || POINTS > `FFIO_MAX_POINTS ||
       (POINTS & (POINTS - 1)) != 0) begin : g_chk_pts
      $error("ffio_top: POINTS must be a power of two in range");
   end
   if (BITS < `FFIO_MIN_BITS || BITS > `FFIO_MAX_BITS) begin : g_chk_b
      $error("ffio_top: BITS out of range");
   end

   // ---------------- state ----------------
   ffio_in_state_e state;        // input side phase
   ffio_in_state_e next_state;   // its next value
   logic [CW-1:0]  in_cnt;       // samples taken at the pins
   logic [CW-1:0]  wr_ptr;       // input buffer write pointer
   logic [CW-1:0]  cp_rd;        // copy read address
   logic           cp_wr_v;      // copy write pending
   logic [AW-1:0]  cp_wr_addr;   // copy write address
   logic [CW-1:0]  rd_ptr;       // output buffer read pointer

   // ---------------- fifo and buffer wires ----------------
   ffio_cplx_s     in_word;      // sample as it enters the fifo
   ffio_cplx_s     fifo_word;    // sample leaving the fifo
   ffio_cplx_s     inbuf_word;   // word read from the input buffer
   ffio_cplx_s     outbuf_word;  // word read from the output buffer
   logic           fifo_wr_ready;
   logic           fifo_rd_valid;
   logic [LW-1:0]  fifo_level;

   // sign extend both parts, taken in the same cycle
   assign in_word.re = {{(`FFIO_MAX_BITS-BITS){in_real_bus[BITS-1]}},
                        in_real_bus};
   assign in_word.im = {{(`FFIO_MAX_BITS-BITS){in_imag_bus[BITS-1]}},
                        in_imag_bus};

   // ---------------- input side decode ----------------
   // a sample is taken only while the accept flag is high
   // and every edge may take one, no gap needed
   wire take = input_accept_flag & in_sample_valid & fifo_wr_ready;
   // drain the fifo into the input buffer while filling
   wire drain_ready = (state == ST_FILL);
   wire drain       = fifo_rd_valid & drain_ready;
   // sample count after this edge
   wire [CW-1:0] next_in_cnt = in_cnt + CW'(take);
   // keep accepting until N are taken and the fifo has room
   wire next_accept = (state == ST_FILL) & (next_in_cnt < N_CNT) &
                      (fifo_level < ROOM);
   // buffer holds a whole frame
   wire frame_full = (wr_ptr == N_CNT);
   // copy read issue and the last copy write
   wire cp_issue = (state == ST_COPY) & (cp_rd < N_CNT);
   wire cp_done  = cp_wr_v & (cp_wr_addr == LAST);

   // ---------------- output side decode ----------------
   // advance acts as a clock enable for the result stream
   wire out_step = output_advance & result_ready & (rd_ptr < N_CNT);
   // advance after the last result closes the frame
   wire out_end  = output_advance & result_ready & (rd_ptr == N_CNT);

   // ---------------- input phase sequencing ----------------
   always_comb begin
      next_state = state;
      unique case (state)
         // whole frame in the buffer: move it on
         ST_FILL: begin
            if (frame_full) begin
               next_state = ST_WAIT;
            end
         end
         // host still reading the previous frame
         ST_WAIT: begin
            if (!result_ready) begin
               next_state = ST_COPY;
            end
         end
         // last word written: open for the next frame
         ST_COPY: begin
            if (cp_done) begin
               next_state = ST_FILL;
            end
         end
      endcase
   end

   // phase register; start returns to the ready state
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_FILL;
      end else if (start) begin
         state <= ST_FILL;
      end else begin
         state <= next_state;
      end
   end

   // accept flag, registered so the pin comes from a flop
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         input_accept_flag <= `FFIO_ACCEPT_RST;
      end else if (start) begin
         input_accept_flag <= `FFIO_ACCEPT_RST;
      end else begin
         input_accept_flag <= next_accept;
      end
   end

   // pin side sample count, cleared when the frame moves on
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         in_cnt <= CW'(`FFIO_PTR_RST);
      end else if (start || cp_done) begin
         in_cnt <= CW'(`FFIO_PTR_RST);
      end else begin
         in_cnt <= next_in_cnt;
      end
   end

   // input buffer write pointer
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= CW'(`FFIO_PTR_RST);
      end else if (start || cp_done) begin
         wr_ptr <= CW'(`FFIO_PTR_RST);
      end else begin
         wr_ptr <= wr_ptr + CW'(drain);
      end
   end

   // copy engine: one read per edge, write lands one edge later
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cp_rd      <= CW'(`FFIO_PTR_RST);
         cp_wr_v    <= 1'b0;
         cp_wr_addr <= AW'(`FFIO_PTR_RST);
      end else if (start || state != ST_COPY) begin
         cp_rd      <= CW'(`FFIO_PTR_RST);
         cp_wr_v    <= 1'b0;
         cp_wr_addr <= AW'(`FFIO_PTR_RST);
      end else begin
         cp_rd      <= cp_rd + CW'(cp_issue);
         cp_wr_v    <= cp_issue;
         cp_wr_addr <= cp_rd[AW-1:0];
      end
   end

   // result ready: set on a complete frame, held while read
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         result_ready <= 1'b0;
      end else if (start) begin
         result_ready <= 1'b0;
      end else if (cp_done) begin
         result_ready <= 1'b1;
      end else if (out_end) begin
         result_ready <= 1'b0;
      end
   end

   // output buffer read pointer, cleared for each new frame
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_ptr <= CW'(`FFIO_PTR_RST);
      end else if (start || cp_done) begin
         rd_ptr <= CW'(`FFIO_PTR_RST);
      end else begin
         rd_ptr <= rd_ptr + CW'(out_step);
      end
   end

   // out valid follows an advance by one edge and holds
   // through pauses, so alternate advance gives two cycles
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         out_sample_valid <= 1'b0;
      end else if (start || out_end) begin
         out_sample_valid <= 1'b0;
      end else if (out_step) begin
         out_sample_valid <= 1'b1;
      end
   end

   // result buses come from the output buffer read register
   assign out_real_bus = outbuf_word.re[BITS-1:0];
   assign out_imag_bus = outbuf_word.im[BITS-1:0];

   // ---------------- instances ----------------
   // elastic fifo in front of the input buffer
   ffio_fifo #(
      .WIDTH ($bits(ffio_cplx_s)),
      .DEPTH (FD)
   ) u_fifo (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .clear    (start),
      .wr_valid (take),
      .wr_ready (fifo_wr_ready),
      .wr_data  (in_word),
      .rd_valid (fifo_rd_valid),
      .rd_ready (drain_ready),
      .rd_data  (fifo_word),
      .level    (fifo_level)
   );

   // input frame buffer
   ffio_frame_ram #(
      .WIDTH ($bits(ffio_cplx_s)),
      .DEPTH (POINTS)
   ) u_inbuf (
      .sys_clk (sys_clk),
      .wr_en   (drain),
      .wr_addr (wr_ptr[AW-1:0]),
      .wr_data (fifo_word),
      .rd_en   (cp_issue),
      .rd_addr (cp_rd[AW-1:0]),
      .rd_data (inbuf_word)
   );

   // output frame buffer, written by the copy engine
   ffio_frame_ram #(
      .WIDTH ($bits(ffio_cplx_s)),
      .DEPTH (POINTS)
   ) u_outbuf (
      .sys_clk (sys_clk),
      .wr_en   (cp_wr_v),
      .wr_addr (cp_wr_addr),
      .wr_data (inbuf_word),
      .rd_en   (out_step),
      .rd_addr (rd_ptr[AW-1:0]),
      .rd_data (outbuf_word)
   );

   // ---------------- assertions ----------------
   a_start_ptrs: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      start |=> (wr_ptr == '0) && (rd_ptr == '0))
      else $error("pointers not cleared by start");

   a_start_ready: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      start |=> input_accept_flag && !result_ready && !out_sample_valid)
      else $error("interface not in ready state after start");

   a_closed_ignores: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      !input_accept_flag && !start |=> in_cnt == $past(in_cnt) ||
                                       in_cnt == '0)
      else $error("sample taken while accept low");

   a_take_counts: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      in_sample_valid && input_accept_flag && !start && !cp_done
      |=> in_cnt == $past(in_cnt) + CW'(1))
      else $error("valid sample not counted");

   a_full_closes: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      in_cnt == N_CNT |-> !input_accept_flag)
      else $error("accept high with full frame");

   a_done_ready: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      cp_done && !start |=> result_ready && rd_ptr == '0)
      else $error("result ready not raised on frame done");

   a_ready_held: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      result_ready && rd_ptr < N_CNT && !start |=> result_ready)
      else $error("result ready dropped mid read");

   a_valid_latency: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      output_advance && result_ready && rd_ptr < N_CNT && !start
      |=> out_sample_valid && rd_ptr == $past(rd_ptr) + CW'(1))
      else $error("result not valid one cycle after advance");

   a_pause_holds: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      out_sample_valid && !output_advance && !start
      |=> out_sample_valid && $stable(out_real_bus) &&
          $stable(out_imag_bus))
      else $error("result changed while advance low");

   a_frame_end: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      output_advance && result_ready && rd_ptr == N_CNT && !start
      |=> !result_ready && !out_sample_valid)
      else $error("ready or valid high after last result");
endmodule

/* tb/ffio_host_model.sv */
// host model that loads input frames and reads result frames
`timescale 1ns/1ps
module ffio_host_model #(
   parameter int POINTS = 32,
   parameter int BITS   = 16
) (
   input  wire logic            sys_clk,
   input  wire logic            rst_n,
   input  wire logic            load_go,
   input  wire logic            load_gap,
   input  wire logic            junk,
   input  wire logic [BITS-1:0] base,
   input  wire logic [1:0]      adv_mode,
   input  wire logic            input_accept_flag,
   output logic                 load_done,
   output logic [BITS-1:0]      in_real_bus,
   output logic [BITS-1:0]      in_imag_bus,
   output logic                 in_sample_valid,
   output logic                 output_advance
);
   int   cnt;     // samples handed over in this frame
   logic gap_ph;  // phase of the gapped load
   logic adv_ph;  // phase of the alternate advance

   // everything toward the block changes on the falling edge
   always @(negedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt             <= 0;
         gap_ph          <= 1'b0;
         adv_ph          <= 1'b0;
         load_done       <= 1'b0;
         in_sample_valid <= 1'b0;
         output_advance  <= 1'b0;
         in_real_bus     <= '0;
         in_imag_bus     <= '1;
      end else begin
         // mode 1 reads steadily, mode 2 every other cycle
         adv_ph         <= (adv_mode == 2'h2) ? ~adv_ph : 1'b0;
         output_advance <= (adv_mode == 2'h1) ||
                           (adv_mode == 2'h2 && !adv_ph);
         // gap phase restarts with every load so its length is fixed
         gap_ph         <= (load_gap && load_go) ? ~gap_ph : 1'b0;
         if (junk && !input_accept_flag) begin
            // offer samples the block has to refuse
            in_sample_valid <= 1'b1;
            in_real_bus     <= ~in_real_bus;
            in_imag_bus     <= ~in_imag_bus;
         end else if (load_go && cnt < POINTS && input_accept_flag &&
                      !gap_ph) begin
            // both parts of one sample in the same cycle
            in_sample_valid <= 1'b1;
            in_real_bus     <= base + BITS'(cnt);
            in_imag_bus     <= base - BITS'(cnt);
            cnt             <= cnt + 1;
            load_done       <= (cnt == POINTS - 1);
         end else begin
            // idle: buses show a changing pattern, not the last value
            in_sample_valid <= 1'b0;
            in_real_bus     <= ~in_real_bus;
            in_imag_bus     <= ~in_imag_bus;
            if (!load_go) begin
               cnt       <= 0;
               load_done <= 1'b0;
            end
         end
      end
   end
endmodule

/* tb/ffio_top_tb.sv */
// self-checking bench for the frame streaming interface
`timescale 1ns/1ps
module ffio_top_tb;
   localparam int POINTS = 32;
   localparam int BITS   = 16;
   logic            sys_clk = 1'b0;
   logic            rst_n   = 1'b0;
   logic            start   = 1'b0;
   logic            load_go = 1'b0;  // partner controls, changed at posedge
   logic            load_gap = 1'b0;
   logic            junk    = 1'b0;
   logic [BITS-1:0] base    = '0;
   logic [1:0]      adv_mode = 2'h0;
   logic            load_done;
   logic [BITS-1:0] in_real_bus;
   logic [BITS-1:0] in_imag_bus;
   logic            in_sample_valid;
   logic            input_accept_flag;
   logic            output_advance;
   logic            result_ready;
   logic            out_sample_valid;
   logic [BITS-1:0] out_real_bus;
   logic [BITS-1:0] out_imag_bus;
   logic [BITS-1:0] first_re;        // first result of the last read
   int              err_total = 0;
   int              compares  = 0;

   // 10 MHz clock
   always #50 sys_clk = ~sys_clk;

   ffio_top #(.POINTS(POINTS), .BITS(BITS)) u_ffio_top (
      .sys_clk(sys_clk), .rst_n(rst_n), .start(start),
      .in_real_bus(in_real_bus), .in_imag_bus(in_imag_bus),
      .in_sample_valid(in_sample_valid),
      .input_accept_flag(input_accept_flag),
      .output_advance(output_advance), .result_ready(result_ready),
      .out_sample_valid(out_sample_valid),
      .out_real_bus(out_real_bus), .out_imag_bus(out_imag_bus));

   ffio_host_model #(.POINTS(POINTS), .BITS(BITS)) u_ffio_host_model (
      .sys_clk(sys_clk), .rst_n(rst_n), .load_go(load_go),
      .load_gap(load_gap), .junk(junk), .base(base),
      .adv_mode(adv_mode), .input_accept_flag(input_accept_flag),
      .load_done(load_done), .in_real_bus(in_real_bus),
      .in_imag_bus(in_imag_bus), .in_sample_valid(in_sample_valid),
      .output_advance(output_advance));

   // closing report and verdict
   task automatic stop_test();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // compare one value, count and report
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // a bounded wait that ran out ends the run
   task automatic give_up(input string what);
      err_total++;
      $display("FAIL %s expected event seen timeout", what);
      stop_test();
   endtask

   // the three handshake flags at once
   task automatic flags(input logic a, input logic r, input logic v);
      check("input_accept_flag", input_accept_flag, a);
      check("result_ready", result_ready, r);
      check("out_sample_valid", out_sample_valid, v);
   endtask

   // partner loads one frame; accept must drop right after the last
   task automatic load_frame(input logic [BITS-1:0] b, input logic gap);
      int n;
      n = 0;
      @(posedge sys_clk);
      base = b;
      load_gap = gap;
      load_go = 1'b1;
      while (load_done !== 1'b1 && n < 500) begin
         @(posedge sys_clk);
         n++;
      end
      if (n == 500) give_up("load_done");
      // an early accept drop would stall the host and stretch the load
      check("load_cycles", n, gap ? 2 * POINTS - 1 : POINTS);
      @(negedge sys_clk);
      check("input_accept_flag", input_accept_flag, 1'b0);
      @(posedge sys_clk);
      load_go = 1'b0;
   endtask

   // bounded wait for a complete result frame
   task automatic wait_ready();
      int n;
      n = 0;
      while (result_ready !== 1'b1 && n < 500) begin
         @(negedge sys_clk);
         n++;
      end
      if (n == 500) give_up("result_ready");
      check("result_ready", result_ready, 1'b1);
   endtask

   // read a frame with advance held high; mode 2 reads every other cycle
   task automatic read_frame(input logic [BITS-1:0] b, input logic alt);
      logic [BITS-1:0] k;
      wait_ready();
      @(posedge sys_clk);
      adv_mode = alt ? 2'h2 : 2'h1;
      @(negedge sys_clk);
      check("out_sample_valid", out_sample_valid, 1'b0);
      for (int i = 0; i < (alt ? 2 * POINTS : POINTS); i++) begin
         @(negedge sys_clk);
         k = alt ? BITS'(i / 2) : BITS'(i);
         if (i == 0) first_re = out_real_bus;
         check("out_sample_valid", out_sample_valid, 1'b1);
         check("result_ready", result_ready, 1'b1);
         check("out_real_bus", out_real_bus, b + k);
         check("out_imag_bus", out_imag_bus, b - k);
      end
      @(negedge sys_clk);
      flags(1'b1, 1'b0, 1'b0);
      @(posedge sys_clk);
      adv_mode = 2'h0;
   endtask

   // flags while in reset and right after release
   task automatic sc_reset();
      repeat (5) @(negedge sys_clk);
      flags(1'b1, 1'b0, 1'b0);
      rst_n = 1'b1;
      @(negedge sys_clk);
      flags(1'b1, 1'b0, 1'b0);
   endtask

   // back-to-back load, refused samples while closed, steady read
   task automatic sc_steady();
      load_frame(16'h0100, 1'b0);
      @(posedge sys_clk);
      junk = 1'b1;
      repeat (8) @(posedge sys_clk);
      junk = 1'b0;
      read_frame(16'h0100, 1'b0);
      check("first_re", first_re, 16'h0100);
   endtask

   // gapped load and alternate read
   task automatic sc_gap();
      load_frame(16'h2200, 1'b1);
      read_frame(16'h2200, 1'b1);
   endtask

   // start during a partial read and a partial load clears both sides
   task automatic sc_start();
      load_frame(16'h3300, 1'b0);
      wait_ready();
      @(posedge sys_clk);
      adv_mode = 2'h1;
      repeat (5) @(posedge sys_clk);
      adv_mode = 2'h0;
      base = 16'h7700;
      load_go = 1'b1;
      repeat (10) @(posedge sys_clk);
      load_go = 1'b0;
      @(negedge sys_clk);
      start = 1'b1;
      @(negedge sys_clk);
      start = 1'b0;
      flags(1'b1, 1'b0, 1'b0);
      load_frame(16'h4400, 1'b0);
      read_frame(16'h4400, 1'b0);
      check("first_re", first_re, 16'h4400);
   endtask

   // main sequence; host drains each frame before the next load, except in sc_start
   initial begin
      rst_n = 1'b0;
      sc_reset();
      sc_steady();
      sc_gap();
      sc_start();
      stop_test();
   end
endmodule
